// ---- common/sclw_pkg.sv ----
package sclw_pkg;
  // strap level codes from the external quantizer
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  localparam logic [1:0] LVL_MID = 2'h1; // three-level straps: middle code
  // register 30 offset and field positions
  localparam logic [4:0] CFG_REG_ADDR = 5'h1E;
  localparam int BIT_SCRAMBLE_OFF = 0;
  localparam int BIT_WARN_OFF = 1;
  localparam int BIT_SHORT_TP = 2;
  localparam int BIT_COPPER_SEL = 3;
  localparam int BIT_LOW_DRIVE = 4;
  localparam int BIT_SHORT_FO = 5;
  localparam int BIT_LONG_WL = 6;
  localparam int BIT_FIBER_SEL = 7;
  localparam int BIT_LOW_RATE = 8;
  localparam int BIT_ONE_RATE = 9;
  localparam int BIT_ADV_FULL_N = 10;
  localparam int BIT_TRANSP_N = 11;
  localparam int BIT_NEG_DIS = 14;
  localparam int BIT_ADV_HALF_N = 15;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // decoded controls of an all-zero register: scrambler and transparent set
  localparam logic [4:0] CTL_RESET = 5'h12;
  // strap sampling delay after reset release
  localparam int STRAP_DELAY_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // warning timing
  localparam int WARN_OFF_MS = 425;
  localparam int WARN_PERIOD_MS = 3800;
  localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam int WARN_OFF_CYC = WARN_OFF_MS * CYC_PER_MS;
  localparam int WARN_PERIOD_CYC = WARN_PERIOD_MS * CYC_PER_MS;

  typedef struct packed {
    logic [1:0] addr4_warning_strap;
    logic [1:0] addr_hi_pair_strap;
    logic [1:0] addr_lo_pair_strap;
    logic [1:0] copper_strap;
    logic [1:0] fiber_strap;
    logic [1:0] duplex_strap;
    logic [1:0] speed_strap;
  } sclw_straps_t;

  typedef struct packed {
    logic copper_link_up;
    logic fiber_link_up;
  } sclw_links_t;

  typedef struct packed {
    logic copper_tx_en;
    logic fiber_tx_en;
  } sclw_tx_t;
endpackage : sclw_pkg

// ---- core/sclw_blank_timer.sv ----
`timescale 1ns/1ns
// period counter that counts only while run is high; blank is high for the first off_cyc of each period
module sclw_blank_timer #(
  parameter int PERIOD_CYC = 380000000,
  parameter int OFF_CYC = 42500000
) (
  input wire logic ref_clk, // device clock
  input wire logic rstn, // async reset, active low
  input wire logic run, // counting allowed
  output logic blank // blanking window
);
  localparam int W = $clog2(PERIOD_CYC);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic blank_r;
  logic blank_nxt;

  initial begin
    if (OFF_CYC < 1 || OFF_CYC >= PERIOD_CYC) $error("blank window must fit the period");
  end

  // restart from zero whenever not running, so first blank starts at once
  always_comb begin
    cnt_nxt = '0;
    blank_nxt = 1'b0;
    if (run) begin
      cnt_nxt = (cnt_r == W'(PERIOD_CYC - 1)) ? '0 : cnt_r + 1'b1;
      blank_nxt = (cnt_nxt < W'(OFF_CYC));
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      blank_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      blank_r <= blank_nxt;
    end
  end

  assign blank = blank_r;
endmodule : sclw_blank_timer

// ---- core/sclw_strap_config.sv ----
`timescale 1ns/1ns
module sclw_strap_config
  import sclw_pkg::*;
#(
  parameter int WARN_PERIOD = WARN_PERIOD_CYC,
  parameter int WARN_OFF = WARN_OFF_CYC
) (
  input wire logic ref_clk, // 100 MHz device clock
  input wire logic rstn, // async power-up reset, active low
  input wire sclw_straps_t straps, // digitized strap level codes
  input wire sclw_links_t links_up, // input link status per interface
  input wire sclw_tx_t tx_req, // datapath wants to transmit
  input wire logic mgmt_wr, // management write strobe
  input wire logic [4:0] mgmt_reg, // management register number
  input wire logic [15:0] mgmt_wdata, // management write data
  output logic [15:0] mgmt_rdata, // register 30 read data
  output logic cfg_valid, // straps have been latched
  output logic [4:0] mgmt_address, // decoded management address
  output logic link_integrity_warning, // warning function enabled by strap
  output sclw_tx_t tx_out_en, // transmitter output enables
  output logic scramble_en, // scrambler/descrambler enable
  output logic eq_bypass, // receive equalizer bypass
  output logic sd_thresh_high, // raised signal-detect threshold
  output logic transparent_mode, // transparent negotiation mode
  output logic forced_mode // single rate forced mode
);
  typedef enum {ST_WAIT, ST_LOAD, ST_RUN} sclw_state_t;

  sclw_state_t st_r, st_nxt;
  logic [$clog2(STRAP_DELAY_CYC + 1)-1:0] dly_r, dly_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic warn_r, warn_nxt;
  logic [15:0] strap_word;
  logic warn_strap;
  logic blank;
  logic warn_active;
  logic timer_run;
  logic [4:0] ctl_r, ctl_nxt;

  // register 30 layout as this block uses it:
  // bit 0  scrambler disable, set by software only
  // bit 1  warning disable, set by software only
  // bit 2  short copper length
  // bit 3  copper interface select (emitter-coupled when set)
  // bit 4  low copper drive
  // bit 5  short fiber length
  // bit 6  long wavelength
  // bit 7  fiber interface select (emitter-coupled when set)
  // bit 8  low rate select
  // bit 9  one rate only
  // bit 10 full duplex advertise, active low
  // bit 11 transparent mode, active low
  // bit 12 plain storage
  // bit 13 plain storage
  // bit 14 negotiation disable
  // bit 15 half duplex advertise, active low

  initial begin
    if (WARN_OFF < 1 || WARN_OFF >= WARN_PERIOD) $error("warning blank must fit its period");
  end

  // four-level pair decode: 0->00, 1/3->10, 2/3->11, full->01
  function automatic logic [1:0] pair_dec(input logic [1:0] lvl);
    case (lvl)
      LVL_ZERO: pair_dec = 2'h0;
      LVL_THIRD: pair_dec = 2'h2;
      LVL_TWO_THIRD: pair_dec = 2'h3;
      default: pair_dec = 2'h1;
    endcase
  endfunction : pair_dec

  // level to field maps used below (level: fields):
  // copper  0: twisted pair; 1/3: emitter-coupled; 2/3: short+low drive; full: short
  // fiber   0: none set; 1/3: select; 2/3: long wavelength; full: short length
  // duplex  0: transparent_n+full_n; mid: none; full: transparent_n
  // speed   0: neg off+one rate+low rate; mid: none; full: neg off+one rate
  // a three-level strap cannot produce the two-thirds code; should the
  // quantizer report it anyway, it is read as full supply, the safer forced mode
  // compose register 30 defaults from the straps
  always_comb begin
    strap_word = CFG_RESET;
    warn_strap = 1'b0;
    // warning enabled only at the middle two levels
    warn_strap = (straps.addr4_warning_strap == LVL_THIRD) ||
                 (straps.addr4_warning_strap == LVL_TWO_THIRD);
    case (straps.copper_strap)
      LVL_THIRD: strap_word[BIT_COPPER_SEL] = 1'b1;
      LVL_TWO_THIRD: begin
        strap_word[BIT_SHORT_TP] = 1'b1;
        strap_word[BIT_LOW_DRIVE] = 1'b1;
      end
      LVL_FULL: strap_word[BIT_SHORT_TP] = 1'b1;
      default: ;
    endcase
    case (straps.fiber_strap)
      LVL_THIRD: strap_word[BIT_FIBER_SEL] = 1'b1;
      LVL_TWO_THIRD: strap_word[BIT_LONG_WL] = 1'b1;
      LVL_FULL: strap_word[BIT_SHORT_FO] = 1'b1;
      default: ;
    endcase
    // three-level duplex strap; the unused two-thirds code reads as full supply
    if (straps.duplex_strap == LVL_ZERO) begin
      strap_word[BIT_TRANSP_N] = 1'b1;
      strap_word[BIT_ADV_FULL_N] = 1'b1;
    end else if (straps.duplex_strap != LVL_MID) begin
      strap_word[BIT_TRANSP_N] = 1'b1;
    end
    if (straps.speed_strap == LVL_ZERO) begin
      strap_word[BIT_NEG_DIS] = 1'b1;
      strap_word[BIT_ONE_RATE] = 1'b1;
      strap_word[BIT_LOW_RATE] = 1'b1;
    end else if (straps.speed_strap != LVL_MID) begin
      strap_word[BIT_NEG_DIS] = 1'b1;
      strap_word[BIT_ONE_RATE] = 1'b1;
    end
    // scrambler-off and warning-off bits start clear: scrambler enabled unless copper select is set
    strap_word[BIT_SCRAMBLE_OFF] = 1'b0;
  end

  // sequencer: wait a few microseconds, latch once, then run
  always_comb begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    cfg_nxt = cfg_r;
    addr_nxt = addr_r;
    warn_nxt = warn_r;
    case (st_r)
      ST_WAIT: begin
        dly_nxt = dly_r + 1'b1;
        if (dly_r == ($bits(dly_r))'(STRAP_DELAY_CYC - 1)) st_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        // single capture; straps are never looked at again
        cfg_nxt = strap_word;
        warn_nxt = warn_strap;
        // address bit 4 is high at two-thirds and full supply
        addr_nxt = {warn_strap ? (straps.addr4_warning_strap == LVL_TWO_THIRD)
                              : (straps.addr4_warning_strap == LVL_FULL),
                    pair_dec(straps.addr_hi_pair_strap),
                    pair_dec(straps.addr_lo_pair_strap)};
        st_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (mgmt_wr && mgmt_reg == CFG_REG_ADDR) cfg_nxt = mgmt_wdata;
      end
      default: st_nxt = ST_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_WAIT;
      dly_r <= '0;
      cfg_r <= CFG_RESET;
      addr_r <= 5'h00;
      warn_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      cfg_r <= cfg_nxt;
      addr_r <= addr_nxt;
      warn_r <= warn_nxt;
    end
  end

  // the warning runs only while the strap enabled it, the disable bit is
  // clear and one rate is configured; software may switch it off, but it
  // cannot switch it in beyond the strap choice, since the same strap level
  // also fixes address bit 4 and the two must stay consistent
  assign warn_active = warn_r && !cfg_r[BIT_WARN_OFF] && cfg_r[BIT_ONE_RATE] &&
                       (st_r == ST_RUN);

  // the period timer runs only with exactly one link down; with both down
  // neither transmitter drives, so counting gains nothing, and a restart on
  // each stop (both links up or both links down) puts the first blank right where a link drops
  assign timer_run = warn_active &&
                     (links_up.copper_link_up ^ links_up.fiber_link_up);

  sclw_blank_timer #(
    .PERIOD_CYC(WARN_PERIOD),
    .OFF_CYC(WARN_OFF)
  ) u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(timer_run),
    .blank(blank)
  );

  // a transmitter blanks while the input link of its own interface is down,
  // so the partner on that side sees its link indicator blink; the gate
  // ignores the rate, so 10 and 100 behave alike
  always_comb begin
    tx_out_en.copper_tx_en = tx_req.copper_tx_en &&
      !(warn_active && !links_up.copper_link_up && blank);
    tx_out_en.fiber_tx_en = tx_req.fiber_tx_en &&
      !(warn_active && !links_up.fiber_link_up && blank);
    // both inputs down: nothing to pass on, both sides stay silent
    if (warn_active && !links_up.copper_link_up && !links_up.fiber_link_up) begin
      tx_out_en = '0;
    end
  end

  // decoded controls of a register 30 word;
  // result order: scramble, eq bypass, threshold, transparent, forced
  function automatic logic [4:0] ctl_dec(input logic [15:0] w);
    logic scr;
    logic eqb;
    logic sdt;
    logic trn;
    logic frc;
    // scrambler belongs to the twisted pair path only
    scr = !w[BIT_COPPER_SEL] && !w[BIT_SCRAMBLE_OFF];
    // 10 m length: short bit set while low drive is clear
    eqb = w[BIT_SHORT_TP] && !w[BIT_LOW_DRIVE] && !w[BIT_COPPER_SEL];
    sdt = w[BIT_SHORT_FO] && !w[BIT_FIBER_SEL];
    // mode from the joint duplex and speed fields
    trn = !w[BIT_TRANSP_N] && !w[BIT_NEG_DIS];
    frc = w[BIT_NEG_DIS] && w[BIT_ONE_RATE];
    ctl_dec = {scr, eqb, sdt, trn, frc};
  endfunction : ctl_dec

  // decode the next register contents, so the registered controls change on
  // the same edge as the register and never lag a write by a cycle
  always_comb begin
    ctl_nxt = ctl_dec(cfg_nxt);
  end

  // decoded controls held in flip-flops to keep decode glitches off the pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= CTL_RESET;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign mgmt_rdata = cfg_r;
  assign cfg_valid = (st_r == ST_RUN);
  assign mgmt_address = addr_r;
  assign link_integrity_warning = warn_r;
  assign scramble_en = ctl_r[4];
  assign eq_bypass = ctl_r[3];
  assign sd_thresh_high = ctl_r[2];
  assign transparent_mode = ctl_r[1];
  assign forced_mode = ctl_r[0];
endmodule : sclw_strap_config

// ---- bench/sclw_strap_config_asserts.sv ----
`timescale 1ns/1ns
// port-level checks of register writes, hold of sampled straps and transmitter gating
module sclw_strap_config_asserts
  import sclw_pkg::*;
#(
  parameter int WARN_PERIOD = 40,
  parameter int WARN_OFF = 5
) (
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset, active low
  input wire sclw_straps_t straps, // strap codes
  input wire sclw_links_t links_up, // link status
  input wire sclw_tx_t tx_req, // transmit requests
  input wire logic mgmt_wr, // write strobe
  input wire logic [4:0] mgmt_reg, // register number
  input wire logic [15:0] mgmt_wdata, // write data
  input wire logic [15:0] mgmt_rdata, // register view
  input wire logic cfg_valid, // straps latched
  input wire logic [4:0] mgmt_address, // address
  input wire logic link_integrity_warning, // warning enable
  input wire sclw_tx_t tx_out_en, // tx enables
  input wire logic scramble_en, // scrambler enabled
  input wire logic eq_bypass, // equalizer bypass
  input wire logic sd_thresh_high, // high threshold
  input wire logic transparent_mode, // transparent
  input wire logic forced_mode // forced rate
);
  logic act;
  logic hit;
  // warning armed only with a single rate and the disable bit clear
  assign act = cfg_valid && link_integrity_warning && !mgmt_rdata[BIT_WARN_OFF]
    && mgmt_rdata[BIT_ONE_RATE];
  assign hit = mgmt_wr && mgmt_reg == CFG_REG_ADDR;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  tx_gate_a: assert property ((tx_out_en & ~tx_req) == 2'h0) else $error("tx without request");
  copper_keep_a: assert property (links_up == 2'h2 |-> tx_out_en.copper_tx_en ==
    tx_req.copper_tx_en) else $error("copper tx blanked while its link is up");
  fiber_keep_a: assert property (links_up == 2'h1 |-> tx_out_en.fiber_tx_en ==
    tx_req.fiber_tx_en) else $error("fiber tx blanked while its link is up");
  both_down_a: assert property (act && links_up == 2'h0 |-> tx_out_en == 2'h0)
    else $error("tx while both links down");
  no_warn_a: assert property (!act |-> tx_out_en == tx_req) else $error("tx gated idle");
  write_take_a: assert property (cfg_valid && hit |=> mgmt_rdata == $past(mgmt_wdata))
    else $error("write not taken");
  write_skip_a: assert property (cfg_valid && !hit |=> $stable(mgmt_rdata))
    else $error("register moved without write");
  strap_hold_a: assert property (cfg_valid |=> cfg_valid && $stable(mgmt_address)
    && $stable(link_integrity_warning)) else $error("sampled straps moved");
  mode_map_a: assert property (cfg_valid |-> transparent_mode ==
    (!mgmt_rdata[BIT_TRANSP_N] && !mgmt_rdata[BIT_NEG_DIS])
    && forced_mode == (mgmt_rdata[BIT_NEG_DIS] && mgmt_rdata[BIT_ONE_RATE]))
    else $error("mode mismatch");
  scram_map_a: assert property (cfg_valid |-> scramble_en ==
    !(mgmt_rdata[BIT_SCRAMBLE_OFF] || mgmt_rdata[BIT_COPPER_SEL])) else $error("scrambler");
endmodule : sclw_strap_config_asserts
bind sclw_strap_config sclw_strap_config_asserts #(.WARN_PERIOD(WARN_PERIOD), .WARN_OFF(WARN_OFF))
  i_chk (.ref_clk(ref_clk), .rstn(rstn), .straps(straps), .links_up(links_up),
  .tx_req(tx_req), .mgmt_wr(mgmt_wr), .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata),
  .mgmt_rdata(mgmt_rdata), .cfg_valid(cfg_valid), .mgmt_address(mgmt_address),
  .link_integrity_warning(link_integrity_warning), .tx_out_en(tx_out_en),
  .scramble_en(scramble_en), .eq_bypass(eq_bypass), .sd_thresh_high(sd_thresh_high),
  .transparent_mode(transparent_mode), .forced_mode(forced_mode));

// ---- bench/sclw_board_model.sv ----
`timescale 1ns/1ns
// board straps: every strap at one level, three-level ones at zero, mid or full
module sclw_board_model
  import sclw_pkg::*;
(
  input wire logic [1:0] lvl, // level for all straps
  input wire logic wiggle, // move straps after sampling
  output sclw_straps_t straps // digitized strap levels
);
  logic [1:0] four;
  logic [1:0] three;
  // three-level straps have no two-thirds code, so it folds to full
  assign three = (lvl == LVL_TWO_THIRD) ? LVL_FULL : lvl;
  // levels turn round after sampling so a late resample shows up
  assign four = wiggle ? ~lvl : lvl;
  assign straps = '{four, four, four, four, four, wiggle ? ~three : three,
    wiggle ? ~three : three};
endmodule : sclw_board_model

// ---- bench/strap_config_and_link_warning_bench.sv ----
`timescale 1ns/1ns
// one reset per strap level, then register, decode and blanking checks
module strap_config_and_link_warning_bench
  import sclw_pkg::*;
;
  localparam int LP = 40;
  localparam int LO = 5;
  localparam logic [15:0] EXP_CFG [4] = '{16'h4F00, 16'h0088, 16'h4A54, 16'h4A24};
  localparam logic [4:0] EXP_ADR [4] = '{5'h00, 5'h0A, 5'h1F, 5'h15};
  localparam logic [3:0] EXP_WARN = 4'h6; // warning enabled at levels 1 and 2
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic mgmt_wr = 1'b0;
  logic wiggle = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [4:0] mgmt_reg = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  sclw_links_t links_up = 2'h3;
  sclw_tx_t tx_req = 2'h3;
  sclw_straps_t straps;
  sclw_tx_t tx_out_en;
  logic [15:0] mgmt_rdata;
  logic [4:0] mgmt_address;
  logic cfg_valid, link_integrity_warning, scramble_en, eq_bypass;
  logic sd_thresh_high, transparent_mode, forced_mode;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  initial forever #5 ref_clk = ~ref_clk;
  sclw_board_model i_board (.lvl(lvl), .wiggle(wiggle), .straps(straps));
  sclw_strap_config #(.WARN_PERIOD(LP), .WARN_OFF(LO)) i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .straps(straps), .links_up(links_up), .tx_req(tx_req), .mgmt_wr(mgmt_wr),
    .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .cfg_valid(cfg_valid), .mgmt_address(mgmt_address),
    .link_integrity_warning(link_integrity_warning), .tx_out_en(tx_out_en),
    .scramble_en(scramble_en), .eq_bypass(eq_bypass), .sd_thresh_high(sd_thresh_high),
    .transparent_mode(transparent_mode), .forced_mode(forced_mode));
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // strobe held one edge, so the write is taken at the edge after it rises
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    @(posedge ref_clk);
    #1 {mgmt_wr, mgmt_reg, mgmt_wdata} = {1'b1, r, d};
    @(posedge ref_clk);
    #1 mgmt_wr = 1'b0;
  endtask : wr
  // blanked cycles per transmitter over exactly one period, any phase gives the same count
  task automatic blanks(input logic [1:0] lk, input int ec, input int ef);
    int c;
    int f;
    c = 0;
    f = 0;
    links_up = lk;
    repeat (3) @(posedge ref_clk);
    repeat (LP) begin
      @(posedge ref_clk);
      #1 c += (tx_out_en.copper_tx_en !== 1'b1);
      f += (tx_out_en.fiber_tx_en !== 1'b1);
    end
    chk(16'(c), 16'(ec));
    chk(16'(f), 16'(ef));
    links_up = 2'h3;
  endtask : blanks
  initial begin
    for (int k = 0; k < 4; k++) begin
      {lvl, wiggle, rstn} = {2'(k), 2'b00};
      repeat (12) @(posedge ref_clk);
      #1 rstn = 1'b1;
      wr(CFG_REG_ADDR, 16'hFFFF); // write before sampling is dropped
      n = 0;
      while (cfg_valid !== 1'b1) begin
        if (++n > 400) begin
          bad_count++;
          give_verdict();
        end
        @(posedge ref_clk);
        #1;
      end
      wiggle = 1'b1;
      @(posedge ref_clk);
      #1 chk(mgmt_rdata, EXP_CFG[k]);
      chk(mgmt_address, EXP_ADR[k]);
      chk(link_integrity_warning, EXP_WARN[k]);
      chk(transparent_mode, k == 1);
      chk(forced_mode, k != 1);
      chk(scramble_en, k != 1);
      chk(eq_bypass, k == 3);
      if (k > 0) chk(sd_thresh_high, k == 3);
      blanks(2'h1, k == 2 ? LO : 0, 0);
      blanks(2'h2, 0, k == 2 ? LO : 0);
      if (k == 2) begin
        blanks(2'h0, LP, LP);
        wr(CFG_REG_ADDR, EXP_CFG[2] & 16'hFDFF);
        chk(forced_mode, 1'b0);
        blanks(2'h1, 0, 0);
      end
      if (k == 0) begin
        wr(5'h1D, 16'h1234);
        chk(mgmt_rdata, EXP_CFG[0]);
        wr(CFG_REG_ADDR, 16'h0001);
        chk(scramble_en, 1'b0);
      end
    end
    give_verdict();
  end
endmodule : strap_config_and_link_warning_bench
